// file: design/tmr8_defs.svh
// Register offsets, field positions, reset values and counts of the 8-bit timer control block.
`ifndef TMR8_DEFS_SVH
`define TMR8_DEFS_SVH

// -----------------------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------------------
`define TMR8_IDX_CTRL_A      6'h24
`define TMR8_IDX_CTRL_B      6'h25
`define TMR8_IDX_COUNTER     6'h26
`define TMR8_IDX_CMP_A       6'h27
`define TMR8_IDX_CMP_B       6'h28
`define TMR8_IDX_STATUS      6'h29
`define TMR8_IDX_PINCFG      6'h2A

// -----------------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------------
`define TMR8_A_COM_A_HI      7
`define TMR8_A_COM_A_LO      6
`define TMR8_A_COM_B_HI      5
`define TMR8_A_COM_B_LO      4
`define TMR8_A_WGM_HI        1
`define TMR8_A_WGM_LO        0
`define TMR8_B_FORCE_A       7
`define TMR8_B_FORCE_B       6
`define TMR8_B_WGM_TOP       3
`define TMR8_B_CS_HI         2
`define TMR8_B_CS_LO         0
`define TMR8_ST_OVF          0
`define TMR8_ST_MATCH_A      1
`define TMR8_ST_MATCH_B      2
`define TMR8_PC_DIR_A        0
`define TMR8_PC_DIR_B        1
`define TMR8_PC_PORT_A       2
`define TMR8_PC_PORT_B       3

// -----------------------------------------------------------------------------
// Reset values and counter limits
// -----------------------------------------------------------------------------
`define TMR8_RST_BYTE        8'h00
`define TMR8_MAX             8'hFF
`define TMR8_BOTTOM          8'h00
`define TMR8_PRESC_W         10
`define TMR8_TAP_8           10'h007
`define TMR8_TAP_64          10'h03F
`define TMR8_TAP_256         10'h0FF
`define TMR8_TAP_1024        10'h3FF

`endif

// file: design/tmr8_pkg.sv
// Types shared by the 8-bit timer control block.
package tmr8_pkg;

   // Waveform class decoded from the 3-bit waveform select.
   typedef enum logic [3:0]
   {
      TMR8_WC_NORMAL = 4'b0001,
      TMR8_WC_CTC    = 4'b0010,
      TMR8_WC_FAST   = 4'b0100,
      TMR8_WC_PHASE  = 4'b1000
   } tmr8_wclass_e;

   // Clock source selection codes.
   typedef enum logic [2:0]
   {
      TMR8_CS_STOP  = 3'h0,
      TMR8_CS_DIV1  = 3'h1,
      TMR8_CS_DIV8  = 3'h2,
      TMR8_CS_DIV64 = 3'h3,
      TMR8_CS_DIV256 = 3'h4,
      TMR8_CS_DIV1024 = 3'h5,
      TMR8_CS_EXT_FALL = 3'h6,
      TMR8_CS_EXT_RISE = 3'h7
   } tmr8_cs_e;

endpackage

// file: design/tmr8_top.sv
// 8-bit timer/counter with waveform modes, force strobes and clock select, on Avalon-MM.
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "tmr8_defs.svh"

module tmr8_top
   import tmr8_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic        i_external_count_pin,
   output logic             o_compare_pin_a,
   output logic             o_compare_pin_a_oe,
   output logic             o_compare_pin_b,
   output logic             o_compare_pin_b_oe
);

   // -----------------------------------------------------------------------------
   // Waveform step for one channel
   // -----------------------------------------------------------------------------
   // Channel A may toggle in PWM modes when the high waveform bit is set; B may not.
   function automatic logic wave_next
   (
      input logic         cur,
      input logic [1:0]   com,
      input tmr8_wclass_e wc,
      input logic         match,
      input logic         force_s,
      input logic         at_bottom,
      input logic         at_top,
      input logic         down,
      input logic         eq_top,
      input logic         tog_ok
   );
      logic r;
      begin
         r = cur;
         unique case (wc)
            TMR8_WC_NORMAL, TMR8_WC_CTC:
            begin
               if (match || force_s)
               begin
                  if (com == 2'h1)
                     r = ~cur;
                  else if (com == 2'h2)
                     r = 1'b0;
                  else if (com == 2'h3)
                     r = 1'b1;
               end
            end
            TMR8_WC_FAST:
            begin
               if (com[1])
               begin
                  if (at_bottom)
                     r = ~com[0];
                  if (match && !eq_top)
                     r = com[0];
               end
               else if (com[0] && tog_ok && match)
                  r = ~cur;
            end
            TMR8_WC_PHASE:
            begin
               if (com[1])
               begin
                  if (eq_top)
                  begin
                     if (at_top)
                        r = ~com[0];
                  end
                  else if (match)
                     r = down ? ~com[0] : com[0];
               end
               else if (com[0] && tog_ok && match)
                  r = ~cur;
            end
         endcase
         wave_next = r;
      end
   endfunction

   // -----------------------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------------------
   logic [1:0]  com_a_reg;
   logic [1:0]  com_b_reg;
   logic [1:0]  wgm_low_reg;
   logic        wgm_high_reg;
   logic [2:0]  cs_reg;
   logic        force_a_reg;
   logic        force_b_reg;
   logic [7:0]  cnt_reg;
   logic        down_reg;
   logic        block_reg;
   logic [7:0]  cmp_a_reg;
   logic [7:0]  cmp_b_reg;
   logic [7:0]  cmp_a_act_reg;
   logic [7:0]  cmp_b_act_reg;
   logic        ovf_reg;
   logic        mat_a_reg;
   logic        mat_b_reg;
   logic [3:0]  pincfg_reg;
   logic        wave_a_reg;
   logic        wave_b_reg;
   logic [`TMR8_PRESC_W-1:0] presc_reg;
   logic        ext_s1_reg;
   logic        ext_s2_reg;
   logic        ext_prev_reg;
   logic        wait_reg;
   logic [31:0] rdata_reg;
   logic        pin_a_reg;
   logic        pin_a_oe_reg;
   logic        pin_b_reg;
   logic        pin_b_oe_reg;

   // -----------------------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------------------
   // One wait state on every access keeps read data and all outputs registered.
   wire         bus_req   = i_avs_read | i_avs_write;
   wire         wr_take   = i_avs_write & ~wait_reg & i_avs_byteenable[0];
   wire         aligned   = (i_avs_address[1:0] == 2'h0);
   wire [5:0]   idx       = i_avs_address[7:2];
   wire [7:0]   wd        = i_avs_writedata[7:0];
   wire         wr_ctrl_a = wr_take & aligned & (idx == `TMR8_IDX_CTRL_A);
   wire         wr_ctrl_b = wr_take & aligned & (idx == `TMR8_IDX_CTRL_B);
   wire         wr_cnt    = wr_take & aligned & (idx == `TMR8_IDX_COUNTER);
   wire         wr_cmp_a  = wr_take & aligned & (idx == `TMR8_IDX_CMP_A);
   wire         wr_cmp_b  = wr_take & aligned & (idx == `TMR8_IDX_CMP_B);
   wire         wr_status = wr_take & aligned & (idx == `TMR8_IDX_STATUS);
   wire         wr_pincfg = wr_take & aligned & (idx == `TMR8_IDX_PINCFG);

   wire [7:0]   rd_ctrl_a = {com_a_reg, com_b_reg, 2'h0, wgm_low_reg};
   wire [7:0]   rd_ctrl_b = {2'h0, 2'h0, wgm_high_reg, cs_reg};
   wire [7:0]   rd_status = {5'h00, mat_b_reg, mat_a_reg, ovf_reg};
   wire [7:0]   rd_byte   =
      !aligned                        ? 8'h00 :
      (idx == `TMR8_IDX_CTRL_A)  ? rd_ctrl_a :
      (idx == `TMR8_IDX_CTRL_B)  ? rd_ctrl_b :
      (idx == `TMR8_IDX_COUNTER) ? cnt_reg :
      (idx == `TMR8_IDX_CMP_A)   ? cmp_a_reg :
      (idx == `TMR8_IDX_CMP_B)   ? cmp_b_reg :
      (idx == `TMR8_IDX_STATUS)  ? rd_status :
      (idx == `TMR8_IDX_PINCFG)  ? {4'h0, pincfg_reg} : 8'h00;

   // -----------------------------------------------------------------------------
   // Mode decode
   // -----------------------------------------------------------------------------
   wire [2:0]    wgm     = {wgm_high_reg, wgm_low_reg};
   wire          is_pc   = (wgm == 3'h1) | (wgm == 3'h5);
   wire          is_fast = (wgm == 3'h3) | (wgm == 3'h7);
   wire          is_ctc  = (wgm == 3'h2);
   // Reserved codes 4 and 6 run as plain normal counting.
   tmr8_wclass_e wclass;
   assign wclass = is_pc   ? TMR8_WC_PHASE :
                   is_fast ? TMR8_WC_FAST  :
                   is_ctc  ? TMR8_WC_CTC   : TMR8_WC_NORMAL;
   wire [7:0]    top     = wgm[1:0] == 2'h2 || wgm[2] ? cmp_a_reg_top() : `TMR8_MAX;

   function automatic logic [7:0] cmp_a_reg_top();
      cmp_a_reg_top = cmp_a_act_reg;
   endfunction

   // -----------------------------------------------------------------------------
   // Clock select and prescaler
   // -----------------------------------------------------------------------------
   // The external pin is sampled twice before use; edges slower than two clocks count.
   wire ext_rise = ext_s2_reg & ~ext_prev_reg;
   wire ext_fall = ~ext_s2_reg & ext_prev_reg;
   wire tick =
      (cs_reg == TMR8_CS_DIV1)     ? 1'b1 :
      (cs_reg == TMR8_CS_DIV8)     ? (presc_reg[2:0] == `TMR8_TAP_8) :
      (cs_reg == TMR8_CS_DIV64)    ? (presc_reg[5:0] == `TMR8_TAP_64) :
      (cs_reg == TMR8_CS_DIV256)   ? (presc_reg[7:0] == `TMR8_TAP_256) :
      (cs_reg == TMR8_CS_DIV1024)  ? (presc_reg == `TMR8_TAP_1024) :
      (cs_reg == TMR8_CS_EXT_FALL) ? ext_fall :
      (cs_reg == TMR8_CS_EXT_RISE) ? ext_rise : 1'b0;

   // -----------------------------------------------------------------------------
   // Counter sequence
   // -----------------------------------------------------------------------------
   wire       at_top    = (cnt_reg == top);
   wire       at_bot    = (cnt_reg == `TMR8_BOTTOM);
   wire       match_a   = tick & ~block_reg & (cnt_reg == cmp_a_act_reg);
   wire       match_b   = tick & ~block_reg & (cnt_reg == cmp_b_act_reg);
   wire       wrap_evt  = tick & at_top & ~is_pc;
   wire       top_evt   = tick & at_top & is_pc & ~down_reg;
   wire       bot_turn  = tick & at_bot & is_pc & down_reg;
   wire       ovf_evt   = is_pc   ? bot_turn :
                          is_fast ? wrap_evt :
                          tick & (cnt_reg == `TMR8_MAX);
   wire       upd_act   = is_pc ? top_evt : is_fast ? wrap_evt : 1'b1;
   wire [7:0] cnt_inc   = cnt_reg + 8'h01;
   wire [7:0] cnt_dec   = cnt_reg - 8'h01;
   wire [7:0] cnt_next  =
      wr_cnt                      ? wd :
      !tick                       ? cnt_reg :
      is_pc && !down_reg && at_top ? cnt_dec :
      is_pc && down_reg && at_bot  ? cnt_inc :
      is_pc && down_reg            ? cnt_dec :
      (is_ctc || is_fast) && at_top ? `TMR8_BOTTOM : cnt_inc;
   wire       down_next =
      !is_pc              ? 1'b0 :
      top_evt             ? 1'b1 :
      bot_turn            ? 1'b0 : down_reg;

   // -----------------------------------------------------------------------------
   // Waveform and pins
   // -----------------------------------------------------------------------------
   wire force_ok = ~is_pc & ~is_fast;
   wire wave_a_next = wave_next(wave_a_reg, com_a_reg, wclass, match_a,
                                force_a_reg & force_ok, wrap_evt, top_evt, down_reg,
                                cmp_a_act_reg == top, wgm_high_reg);
   wire wave_b_next = wave_next(wave_b_reg, com_b_reg, wclass, match_b,
                                force_b_reg & force_ok, wrap_evt, top_evt, down_reg,
                                cmp_b_act_reg == top, 1'b0);
   wire con_a = (com_a_reg != 2'h0);
   wire con_b = (com_b_reg != 2'h0);

   // -----------------------------------------------------------------------------
   // Bus slave flops
   // -----------------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wait_reg  <= 1'b1;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wait_reg <= ~(bus_req & wait_reg);
         if (i_avs_read & wait_reg)
            rdata_reg <= {24'h00_0000, rd_byte};
      end
   end

   // -----------------------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         com_a_reg    <= 2'h0;
         com_b_reg    <= 2'h0;
         wgm_low_reg  <= 2'h0;
         wgm_high_reg <= 1'b0;
         cs_reg       <= 3'h0;
         force_a_reg  <= 1'b0;
         force_b_reg  <= 1'b0;
         cmp_a_reg    <= `TMR8_RST_BYTE;
         cmp_b_reg    <= `TMR8_RST_BYTE;
         pincfg_reg   <= 4'h0;
      end
      else
      begin
         // Force bits are one-cycle strobes and are never stored.
         force_a_reg <= wr_ctrl_b & wd[`TMR8_B_FORCE_A];
         force_b_reg <= wr_ctrl_b & wd[`TMR8_B_FORCE_B];
         if (wr_ctrl_a)
         begin
            com_a_reg   <= wd[`TMR8_A_COM_A_HI:`TMR8_A_COM_A_LO];
            com_b_reg   <= wd[`TMR8_A_COM_B_HI:`TMR8_A_COM_B_LO];
            wgm_low_reg <= wd[`TMR8_A_WGM_HI:`TMR8_A_WGM_LO];
         end
         if (wr_ctrl_b)
         begin
            wgm_high_reg <= wd[`TMR8_B_WGM_TOP];
            cs_reg       <= wd[`TMR8_B_CS_HI:`TMR8_B_CS_LO];
         end
         if (wr_cmp_a)
            cmp_a_reg <= wd;
         if (wr_cmp_b)
            cmp_b_reg <= wd;
         if (wr_pincfg)
            pincfg_reg <= wd[3:0];
      end
   end

   // -----------------------------------------------------------------------------
   // Counter, flags and waveform
   // -----------------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         cnt_reg       <= `TMR8_RST_BYTE;
         down_reg      <= 1'b0;
         block_reg     <= 1'b0;
         cmp_a_act_reg <= `TMR8_RST_BYTE;
         cmp_b_act_reg <= `TMR8_RST_BYTE;
         ovf_reg       <= 1'b0;
         mat_a_reg     <= 1'b0;
         mat_b_reg     <= 1'b0;
         wave_a_reg    <= 1'b0;
         wave_b_reg    <= 1'b0;
         presc_reg     <= '0;
      end
      else
      begin
         cnt_reg   <= cnt_next;
         down_reg  <= down_next;
         // A counter write hides the compare match on the next timer clock.
         block_reg <= wr_cnt | (block_reg & ~tick);
         presc_reg <= presc_reg + 1'b1;
         if (upd_act)
         begin
            cmp_a_act_reg <= cmp_a_reg;
            cmp_b_act_reg <= cmp_b_reg;
         end
         // Hardware set wins over a write-one clear in the same cycle.
         ovf_reg   <= ovf_evt | (ovf_reg & ~(wr_status & wd[`TMR8_ST_OVF]));
         mat_a_reg <= match_a | (mat_a_reg & ~(wr_status & wd[`TMR8_ST_MATCH_A]));
         mat_b_reg <= match_b | (mat_b_reg & ~(wr_status & wd[`TMR8_ST_MATCH_B]));
         wave_a_reg <= wave_a_next;
         wave_b_reg <= wave_b_next;
      end
   end

   // -----------------------------------------------------------------------------
   // External pin synchroniser and pin outputs
   // -----------------------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         ext_s1_reg   <= 1'b0;
         ext_s2_reg   <= 1'b0;
         ext_prev_reg <= 1'b0;
         pin_a_reg    <= 1'b0;
         pin_a_oe_reg <= 1'b0;
         pin_b_reg    <= 1'b0;
         pin_b_oe_reg <= 1'b0;
      end
      else
      begin
         ext_s1_reg   <= i_external_count_pin;
         ext_s2_reg   <= ext_s1_reg;
         ext_prev_reg <= ext_s2_reg;
         pin_a_reg    <= con_a ? wave_a_reg : pincfg_reg[`TMR8_PC_PORT_A];
         pin_a_oe_reg <= pincfg_reg[`TMR8_PC_DIR_A];
         pin_b_reg    <= con_b ? wave_b_reg : pincfg_reg[`TMR8_PC_PORT_B];
         pin_b_oe_reg <= pincfg_reg[`TMR8_PC_DIR_B];
      end
   end

   assign o_avs_readdata     = rdata_reg;
   assign o_avs_waitrequest  = wait_reg;
   assign o_compare_pin_a    = pin_a_reg;
   assign o_compare_pin_a_oe = pin_a_oe_reg;
   assign o_compare_pin_b    = pin_b_reg;
   assign o_compare_pin_b_oe = pin_b_oe_reg;

endmodule

// file: test/tmr8_top_assertions.sv
// Checker for the 8-bit timer control block, bound to its top module.
`timescale 1ns/1ps
module tmr8_chk (
   input wire logic        i_clk,
   input wire logic        i_nrst,
   input wire logic [7:0]  i_avs_address,
   input wire logic        i_avs_read,
   input wire logic        i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0]  i_avs_byteenable,
   input wire logic [31:0] o_avs_readdata,
   input wire logic        o_avs_waitrequest,
   input wire logic        i_external_count_pin,
   input wire logic        o_compare_pin_a,
   input wire logic        o_compare_pin_a_oe,
   input wire logic        o_compare_pin_b,
   input wire logic        o_compare_pin_b_oe
);
   logic [7:0] sh_a, sh_b, sh_p;
   logic [2:0] quiet;
   wire  [5:0] idx = i_avs_address[7:2];
   wire        acc = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0];
   wire        rda = i_avs_read && !o_avs_waitrequest;
   wire        fcb = acc && idx == 6'h25 && i_avs_writedata[6] && i_avs_writedata[2:0] == 3'h0
                     && sh_b[2:0] == 3'h0 && quiet == 3'h7;
   // Shadow bytes and a quiet counter let properties wait out the pin pipeline.
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         sh_a <= 8'h00;
         sh_b <= 8'h00;
         sh_p <= 8'h00;
         quiet <= 3'h0;
      end
      else
      begin
         if (acc && idx == 6'h24) sh_a <= i_avs_writedata[7:0];
         if (acc && idx == 6'h25) sh_b <= i_avs_writedata[7:0];
         if (acc && idx == 6'h2A) sh_p <= i_avs_writedata[7:0];
         quiet <= acc ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
      end
   end
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   property p_rd_a; rda && idx == 6'h24 |-> o_avs_readdata[3:2] == 2'h0; endproperty
   a_rd_a: assert property (p_rd_a) else $error("control A spare bits set");
   property p_rd_b; rda && idx == 6'h25 |-> o_avs_readdata[7:4] == 4'h0; endproperty
   a_rd_b: assert property (p_rd_b) else $error("control B strobe bits set");
   property p_oe; quiet >= 3'h3 |-> o_compare_pin_b_oe == sh_p[1] && o_compare_pin_a_oe == sh_p[0];
   endproperty
   a_oe: assert property (p_oe) else $error("pin enable differs from direction");
   property p_port; quiet >= 3'h3 && sh_a[5:4] == 2'h0 |-> o_compare_pin_b == sh_p[3]; endproperty
   a_port: assert property (p_port) else $error("pin B not on port bit");
   property p_stop; sh_b[2:0] == 3'h0 && quiet == 3'h7 |-> $stable(o_compare_pin_b); endproperty
   a_stop: assert property (p_stop) else $error("pin B moved while stopped");
   property p_pwm_force; fcb && sh_a[0] |=> $stable(o_compare_pin_b)[*4]; endproperty
   a_pwm_force: assert property (p_pwm_force) else $error("force acted in PWM");
   // Strobe, waveform and pin flops each add one edge after the write lands.
   property p_force; fcb && !sh_a[0] && sh_a[5] |-> ##3 o_compare_pin_b == sh_a[4]; endproperty
   a_force: assert property (p_force) else $error("force set or clear missed");
   property p_toggle;
      fcb && !sh_a[0] && sh_a[5:4] == 2'h1 |-> ##3 o_compare_pin_b != $past(o_compare_pin_b, 3);
   endproperty
   a_toggle: assert property (p_toggle) else $error("force toggle missed");
endmodule
bind tmr8_top tmr8_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(i_avs_address),
   .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
   .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
   .o_avs_waitrequest(o_avs_waitrequest), .i_external_count_pin(i_external_count_pin),
   .o_compare_pin_a(o_compare_pin_a), .o_compare_pin_a_oe(o_compare_pin_a_oe),
   .o_compare_pin_b(o_compare_pin_b), .o_compare_pin_b_oe(o_compare_pin_b_oe));

// file: test/tmr8_pin_model.sv
// Port pin model: pulls the compare pad up and pulses the count pin.
`timescale 1ns/1ps
module tmr8_pin_model (
   input  wire logic i_clk,
   input  wire logic i_oe,
   input  wire logic i_lvl,
   output logic      o_pad,
   output logic      o_count_pin
);
   // An undriven pad floats to the pull-up, never to the last driven level.
   assign o_pad = i_oe ? i_lvl : 1'b1;
   initial o_count_pin = 1'b0;
   // Pulses are four cycles wide so the two-flop synchroniser never misses one.
   task automatic pulses(input int n);
      repeat (n)
      begin
         repeat (4) @(posedge i_clk);
         o_count_pin <= 1'b1;
         repeat (4) @(posedge i_clk);
         o_count_pin <= 1'b0;
      end
   endtask
endmodule

// file: test/tmr8_top_test.sv
// Self-checking bench of the 8-bit timer control block.
`timescale 1ns/1ps
module tmr8_top_test import tmr8_pkg::*;;
   localparam logic [7:0] CA = 8'h90, CB = 8'h94, CN = 8'h98, OA = 8'h9C;
   localparam logic [7:0] OB = 8'hA0, ST = 8'hA4, PC = 8'hA8;
   logic i_clk, i_nrst, rq, wr, wq, oea, pa, oeb, pb, pad, cp;
   logic [7:0]  ad, q;
   logic [31:0] wd, rd;
   logic [3:0]  be;
   int err_count, num_checks, cyc, n;
   tmr8_top dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(ad), .i_avs_read(rq),
      .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rd),
      .o_avs_waitrequest(wq), .i_external_count_pin(cp), .o_compare_pin_a(pa),
      .o_compare_pin_a_oe(oea), .o_compare_pin_b(pb), .o_compare_pin_b_oe(oeb));
   tmr8_pin_model pm (.i_clk(i_clk), .i_oe(oeb), .i_lvl(pb), .o_pad(pad), .o_count_pin(cp));
   initial
   begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end
   always @(posedge i_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         err_count = err_count + 1;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One bus access; the request stands until waitrequest is sampled low.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      ad <= a;
      wd <= {24'h000000, d};
      wr <= w;
      rq <= !w;
      @(posedge i_clk);
      while (wq !== 1'b0) @(posedge i_clk);
      q = rd[7:0];
      wr <= 1'b0;
      rq <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   task automatic t_regs();
      xfer(1'b1, CA, 8'hFC);
      rchk(CA, 8'hF0);
      xfer(1'b1, CB, 8'hFF);
      rchk(CB, 8'h0F);
      xfer(1'b1, CB, 8'h00);
      xfer(1'b1, CA, 8'h00);
      be <= 4'hE;
      xfer(1'b1, CA, 8'h33);
      be <= 4'hF;
      rchk(CA, 8'h00);
      rchk(8'hFC, 8'h00);
      $display("regs test done");
   endtask
   task automatic t_force();
      logic [1:0] cm[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
      logic       ex[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      xfer(1'b1, PC, 8'h02);
      for (int i = 0; i < 4; i++)
      begin
         xfer(1'b1, CA, {2'h0, cm[i], 4'h0});
         repeat (8) @(posedge i_clk);
         xfer(1'b1, CB, 8'h40);
         repeat (3) @(posedge i_clk);
         chk({7'h00, pb}, {7'h00, ex[i]});
      end
      chk({7'h00, oeb}, 8'h01);
      xfer(1'b1, CA, 8'h00);
      xfer(1'b1, PC, 8'h0A);
      repeat (4) @(posedge i_clk);
      chk({7'h00, pb}, 8'h01);
      xfer(1'b1, CA, 8'h21);
      repeat (8) @(posedge i_clk);
      q = {7'h00, pb};
      xfer(1'b1, CB, 8'h40);
      repeat (3) @(posedge i_clk);
      chk({7'h00, pb}, q);
      xfer(1'b1, CA, 8'hB2);
      xfer(1'b1, OA, 8'h10);
      xfer(1'b1, CN, 8'h05);
      xfer(1'b1, ST, 8'h07);
      repeat (8) @(posedge i_clk);
      xfer(1'b1, CB, 8'hC0);
      rchk(CN, 8'h05);
      rchk(ST, 8'h00);
      chk({7'h00, pa}, 8'h00);
      $display("force test done");
   endtask
   task automatic t_clock();
      int dv[5] = '{1, 8, 64, 256, 1024};
      xfer(1'b1, CA, 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         xfer(1'b1, CN, 8'h00);
         xfer(1'b1, CB, 8'(i + 1));
         repeat (20 * dv[i]) @(posedge i_clk);
         xfer(1'b1, CB, 8'h00);
         xfer(1'b0, CN, 8'h00);
         chk({7'h00, q >= 8'h13 && q <= 8'h18}, 8'h01);
      end
      repeat (40) @(posedge i_clk);
      rchk(CN, q);
      xfer(1'b1, PC, 8'h03);
      xfer(1'b1, CN, 8'h00);
      xfer(1'b1, CB, {5'h00, TMR8_CS_EXT_RISE});
      pm.pulses(5);
      repeat (6) @(posedge i_clk);
      rchk(CN, 8'h05);
      xfer(1'b1, CB, {5'h00, TMR8_CS_EXT_FALL});
      pm.pulses(5);
      repeat (6) @(posedge i_clk);
      rchk(CN, 8'h0A);
      $display("clock test done");
   endtask
   task automatic t_duty();
      logic [7:0] ta[6] = '{8'h23, 8'h33, 8'h21, 8'h31, 8'h23, 8'h21};
      logic [7:0] tb[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h09, 8'h09};
      int         ex[6] = '{510, 1530, 512, 1528, 1020, 1028};
      xfer(1'b1, CB, 8'h00);
      xfer(1'b1, CA, 8'h00);
      xfer(1'b1, PC, 8'h02);
      xfer(1'b1, OA, 8'h7F);
      xfer(1'b1, OB, 8'h40);
      for (int i = 0; i < 6; i++)
      begin
         xfer(1'b1, CA, ta[i]);
         xfer(1'b1, CB, tb[i]);
         n = 0;
         repeat (2040) @(posedge i_clk) n += int'(pad === 1'b1);
         chk({7'h00, n > ex[i] - 80 && n < ex[i] + 80}, 8'h01);
      end
      xfer(1'b1, CB, 8'h00);
      $display("duty test done");
   endtask
   initial
   begin
      {rq, wr, ad, wd, be, i_nrst} = '0;
      {err_count, num_checks, cyc} = '0;
      be = 4'hF;
      repeat (5) @(posedge i_clk);
      i_nrst <= 1'b1;
      t_regs();
      t_force();
      t_clock();
      t_duty();
      close_out();
   end
endmodule
